// ### include/spcs_regs.vh
// Purpose: Register map, field positions, reset values and counts of the serial port.
// Assumes: Byte-wide register port, one register per address.
// Notes: How it works list below.
// How it works
// [RULE1] Invalid stop bit sets framing error flag.
// [RULE2] Framing error stays set until software clears.
// [RULE3] Control bit 7 is framing error or mode bit.
// [RULE4] Framing error sets even when hidden.
// [RULE5] Two mode bits pick one of four modes.
// [RULE6] Nine-bit filter needs ninth bit and address match.
// [RULE7] Eight-bit filter needs valid stop and match.
// [RULE8] Software keeps filter off in shift mode.
// [RULE9] Reception only while receive enable is set.
// [RULE10] Nine-bit frames send software ninth bit.
// [RULE11] Received ninth bit field per mode.
// [RULE12] Transmit done at bit 8 or stop start.
// [RULE13] Receive done at bit 8 or stop middle.
// [RULE14] Software clears both done flags itself.
// [RULE15] Buffer write starts transmit; reads see receive.
// [RULE16] Reception start condition depends on mode.
// [RULE17] Fixed nine-bit rate is osc/32 or osc/16.
// [RULE18] Flag writes act directly, zero clears.
// [RULE19] Done flags raise interrupt request until cleared.
`ifndef SPCS_REGS_VH
`define SPCS_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPCS_OFF_CTRL 3'h0
`define SPCS_OFF_SERIAL_BUFFER 3'h1
`define SPCS_OFF_POWER_CONTROL_REG 3'h2
`define SPCS_OFF_GADDR 3'h3
`define SPCS_OFF_BADDR 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPCS_B_BIT7 7
`define SPCS_B_SM1 6
`define SPCS_B_FILT 5
`define SPCS_B_REN 4
`define SPCS_B_TB8 3
`define SPCS_B_RB8 2
`define SPCS_B_TI 1
`define SPCS_B_RI 0
`define SPCS_B_BAUD_DBL 7
`define SPCS_B_SEL7 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPCS_RST_CTRL 8'h00
`define SPCS_RST_POWER_CONTROL_REG 8'h00
`define SPCS_RST_GADDR 8'h00
`define SPCS_RST_BADDR 8'hFF

// ----------------------------------------
// Modes and counts
// ----------------------------------------
`define SPCS_MODE_SHIFT 2'h0
`define SPCS_MODE_U8 2'h1
`define SPCS_MODE_U9F 2'h2
`define SPCS_MODE_U9V 2'h3
`define SPCS_CNT_LAST 4'hF
`define SPCS_SMP_A 4'h7
`define SPCS_SMP_B 4'h8
`define SPCS_SMP_C 4'h9
`define SPCS_M0_LAST 4'h7
`define SPCS_STOP_U8 4'h9
`define SPCS_STOP_U9 4'hA

`endif

// ### rtl/spcs_buf2.v
// Purpose: Two-entry buffer between the receiver and the receive register.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Ready on the fill side is low only when both entries hold data.
`timescale 1ns/100ps
module spcs_buf2 (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_valid,
  output wire o_ready,
  input wire [9:0] i_data,
  output wire o_valid,
  input wire i_ready,
  output wire [9:0] o_data
);
  reg [9:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign o_data = mem[rd_ptr];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= i_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push & ~pop) begin
        count <= count + 2'h1;
      end else if (pop & ~push) begin
        count <= count - 2'h1;
      end
    end
  end
endmodule // spcs_buf2

// ### rtl/spcs_top.v
// Purpose: Control, status and frame engine of the four-mode serial port.
// Assumes: Pins and strobes synchronous to i_clk; i_t1_ovf is a one-cycle timer overflow.
// Notes: Received words pass a two-entry buffer; a full buffer holds off new receptions.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/100ps
`include "spcs_regs.vh"
module spcs_top (
  input wire i_clk,
  input wire i_rst_n,
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_t1_ovf,
  input wire i_rxd,
  output reg o_rxd,
  output reg o_rxd_oe_n,
  output reg o_txd,
  output reg o_irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_M0 = 2'h1;
  localparam ST_UART = 2'h2;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg fe, sm0, sm1, filt, ren, tb8, rb8, ti, ri, baud_dbl, sel7;
  reg [7:0] gaddr, baddr, rx_data;
  wire [1:0] mode;
  wire nine, wr_ctrl, wr_serial_buffer, wr_power_control_reg, tick;

  assign mode = {sm0, sm1}; // [RULE5]
  assign nine = sm0;
  assign wr_ctrl = i_wr & (i_addr == `SPCS_OFF_CTRL);
  assign wr_serial_buffer = i_wr & (i_addr == `SPCS_OFF_SERIAL_BUFFER);
  assign wr_power_control_reg = i_wr & (i_addr == `SPCS_OFF_POWER_CONTROL_REG);

  // ----------------------------------------
  // Sample tick, sixteen per bit
  // ----------------------------------------
  reg div2, t1_half;

  // Fixed mode: osc/32 gives osc/2 ticks, osc/16 gives one tick per clock
  assign tick = (mode == `SPCS_MODE_U9F) ? (baud_dbl | div2) :
                (i_t1_ovf & (baud_dbl | t1_half)); // [RULE17]

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      div2 <= 1'b0;
      t1_half <= 1'b0;
    end else begin
      div2 <= ~div2;
      if (i_t1_ovf) begin
        t1_half <= ~t1_half;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  reg [1:0] tx_state;
  reg [10:0] tx_frame;
  reg [3:0] tx_bitn, tx_cnt, tx_last;
  reg tx_ph, ti_set;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      tx_state <= ST_IDLE;
      tx_frame <= 11'h7FF;
      tx_bitn <= 4'h0;
      tx_cnt <= 4'h0;
      tx_last <= `SPCS_STOP_U8;
      tx_ph <= 1'b0;
      ti_set <= 1'b0;
    end else begin
      ti_set <= 1'b0;
      if (wr_serial_buffer) begin
        tx_frame <= {1'b1, (nine ? tb8 : 1'b1), i_wdata, 1'b0}; // [RULE10] [RULE15]
        tx_last <= nine ? `SPCS_STOP_U9 : `SPCS_STOP_U8;
        tx_bitn <= 4'h0;
        tx_cnt <= 4'h0;
        tx_ph <= 1'b0;
        tx_state <= (mode == `SPCS_MODE_SHIFT) ? ST_M0 : ST_UART;
      end else begin
        case (tx_state)
          ST_M0: begin
            tx_ph <= ~tx_ph;
            if (tx_ph) begin
              if (tx_bitn == `SPCS_M0_LAST) begin
                ti_set <= 1'b1; // [RULE12]
                tx_state <= ST_IDLE;
              end else begin
                tx_bitn <= tx_bitn + 4'h1;
              end
            end
          end
          ST_UART: begin
            if (tick) begin
              if (tx_cnt == `SPCS_CNT_LAST) begin
                tx_cnt <= 4'h0;
                if (tx_bitn == tx_last) begin
                  tx_state <= ST_IDLE;
                end else begin
                  tx_bitn <= tx_bitn + 4'h1;
                  if (tx_bitn + 4'h1 == tx_last) begin
                    ti_set <= 1'b1; // [RULE12]
                  end
                end
              end else begin
                tx_cnt <= tx_cnt + 4'h1;
              end
            end
          end
          default: tx_state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  reg [1:0] rx_state;
  reg [3:0] rx_bitn, rx_cnt;
  reg rx_ph, rx_ninth, s7, s8, rx_prev, rx_push, fe_set;
  reg [7:0] rx_byte;
  reg [9:0] rx_push_data;
  wire maj, match, buf_in_ready, buf_valid, pop;
  wire [3:0] rx_stop;
  wire [9:0] buf_data;

  assign maj = (s7 & s8) | (s7 & i_rxd) | (s8 & i_rxd);
  assign match = (rx_byte == gaddr) | (rx_byte == baddr);
  assign rx_stop = nine ? `SPCS_STOP_U9 : `SPCS_STOP_U8;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_state <= ST_IDLE;
      rx_bitn <= 4'h0;
      rx_cnt <= 4'h0;
      rx_ph <= 1'b0;
      rx_byte <= 8'h00;
      rx_ninth <= 1'b0;
      s7 <= 1'b1;
      s8 <= 1'b1;
      rx_prev <= 1'b1;
      rx_push <= 1'b0;
      rx_push_data <= 10'h000;
      fe_set <= 1'b0;
    end else begin
      rx_prev <= i_rxd;
      rx_push <= 1'b0;
      fe_set <= 1'b0;
      case (rx_state)
        ST_IDLE: begin
          rx_bitn <= 4'h0;
          rx_cnt <= 4'h0;
          rx_ph <= 1'b0;
          // Empty buffer keeps a finished word from being overrun by the next one
          if (ren && mode == `SPCS_MODE_SHIFT && !ri && !buf_valid &&
              tx_state == ST_IDLE) begin
            rx_state <= ST_M0; // [RULE16] [RULE9]
          end else if (ren && mode != `SPCS_MODE_SHIFT && rx_prev && !i_rxd &&
                       buf_in_ready) begin
            rx_state <= ST_UART; // [RULE16] [RULE9]
          end
        end
        ST_M0: begin
          rx_ph <= ~rx_ph;
          if (!ren) begin
            rx_state <= ST_IDLE; // [RULE9]
          end else if (rx_ph) begin
            rx_byte <= {i_rxd, rx_byte[7:1]};
            rx_bitn <= rx_bitn + 4'h1;
            if (rx_bitn == `SPCS_M0_LAST) begin
              rx_push <= 1'b1; // [RULE13]
              rx_push_data <= {2'h0, i_rxd, rx_byte[7:1]}; // [RULE11]
              rx_state <= ST_IDLE;
            end
          end
        end
        ST_UART: begin
          if (!ren) begin
            rx_state <= ST_IDLE; // [RULE9]
          end else if (tick) begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == `SPCS_CNT_LAST) begin
              rx_bitn <= rx_bitn + 4'h1;
            end
            if (rx_cnt == `SPCS_SMP_A) begin
              s7 <= i_rxd;
            end
            if (rx_cnt == `SPCS_SMP_B) begin
              s8 <= i_rxd;
            end
            if (rx_cnt == `SPCS_SMP_C) begin
              if (rx_bitn == 4'h0) begin
                if (maj) begin
                  rx_state <= ST_IDLE;
                end
              end else if (rx_bitn == rx_stop) begin
                fe_set <= ~maj; // [RULE1] [RULE4]
                rx_state <= ST_IDLE;
                if (!nine) begin
                  rx_push <= ~filt | (maj & match); // [RULE7] [RULE13]
                  rx_push_data <= {1'b1, maj, rx_byte}; // [RULE11]
                end else begin
                  rx_push <= ~filt | (rx_ninth & match); // [RULE6] [RULE13]
                  rx_push_data <= {1'b1, rx_ninth, rx_byte}; // [RULE11]
                end
              end else if (rx_bitn == `SPCS_STOP_U8) begin
                rx_ninth <= maj;
              end else begin
                rx_byte <= {maj, rx_byte[7:1]};
              end
            end
          end
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  // Buffer drains only while the receive-done flag is clear
  assign pop = buf_valid & ~ri;

  spcs_buf2 u_buf (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_valid(rx_push),
    .o_ready(buf_in_ready),
    .i_data(rx_push_data),
    .o_valid(buf_valid),
    .i_ready(~ri),
    .o_data(buf_data)
  );

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      {fe, sm1, filt, ren, tb8, rb8, ti, ri} <= `SPCS_RST_CTRL;
      sm0 <= 1'b0;
      {baud_dbl, sel7} <= 2'h0;
      gaddr <= `SPCS_RST_GADDR;
      baddr <= `SPCS_RST_BADDR;
      rx_data <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        if (sel7) begin
          fe <= i_wdata[`SPCS_B_BIT7]; // [RULE3] [RULE18] [RULE2]
        end else begin
          sm0 <= i_wdata[`SPCS_B_BIT7]; // [RULE3]
        end
        sm1 <= i_wdata[`SPCS_B_SM1];
        filt <= i_wdata[`SPCS_B_FILT];
        ren <= i_wdata[`SPCS_B_REN];
        tb8 <= i_wdata[`SPCS_B_TB8];
        rb8 <= i_wdata[`SPCS_B_RB8];
        ti <= i_wdata[`SPCS_B_TI]; // [RULE18]
        ri <= i_wdata[`SPCS_B_RI]; // [RULE18]
      end
      if (wr_power_control_reg) begin
        baud_dbl <= i_wdata[`SPCS_B_BAUD_DBL];
        sel7 <= i_wdata[`SPCS_B_SEL7];
      end
      if (i_wr && i_addr == `SPCS_OFF_GADDR) begin
        gaddr <= i_wdata;
      end
      if (i_wr && i_addr == `SPCS_OFF_BADDR) begin
        baddr <= i_wdata;
      end
      // Hardware sets come last so they win over a clear in the same cycle
      if (fe_set) begin
        fe <= 1'b1; // [RULE1] [RULE2]
      end
      if (ti_set) begin
        ti <= 1'b1; // [RULE12]
      end
      if (pop) begin
        rx_data <= buf_data[7:0]; // [RULE15]
        ri <= 1'b1; // [RULE13]
        if (buf_data[9]) begin
          rb8 <= buf_data[8]; // [RULE11]
        end
      end
    end
  end

  // ----------------------------------------
  // Read port and pins
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
      o_txd <= 1'b1;
      o_rxd <= 1'b1;
      o_rxd_oe_n <= 1'b1;
    end else begin
      o_irq <= ti | ri; // [RULE19]
      o_rdata <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `SPCS_OFF_CTRL: o_rdata <= {(sel7 ? fe : sm0), sm1, filt, ren,
                                      tb8, rb8, ti, ri}; // [RULE3]
          `SPCS_OFF_SERIAL_BUFFER: o_rdata <= rx_data; // [RULE15]
          `SPCS_OFF_POWER_CONTROL_REG: o_rdata <= {baud_dbl, sel7, 6'h00};
          `SPCS_OFF_GADDR: o_rdata <= gaddr;
          `SPCS_OFF_BADDR: o_rdata <= baddr;
          default: o_rdata <= 8'h00;
        endcase
      end
      // Shift clock falls as each bit appears and rises mid-bit, so the far side
      // samples settled data on its rising edge
      if (tx_state == ST_M0) begin
        o_txd <= tx_ph; // [RULE5]
        o_rxd <= tx_frame[tx_bitn + 4'h1];
        o_rxd_oe_n <= 1'b0;
      end else if (rx_state == ST_M0) begin
        o_txd <= rx_ph;
        o_rxd <= 1'b1;
        o_rxd_oe_n <= 1'b1;
      end else if (tx_state == ST_UART) begin
        o_txd <= tx_frame[tx_bitn];
        o_rxd <= 1'b1;
        o_rxd_oe_n <= 1'b1;
      end else begin
        o_txd <= 1'b1;
        o_rxd <= 1'b1;
        o_rxd_oe_n <= 1'b1;
      end
    end
  end
endmodule // spcs_top

// ### tb/spcs_checker.sv
// Purpose: Port-level checks of the serial port control block.
// Assumes: Single clock, synchronous active-low reset.
// Notes: Bound to spcs_top and sees its ports only.
`timescale 1ns/100ps
module spcs_checker (
  input wire i_clk,
  input wire i_rst_n,
  input wire [2:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire o_rxd,
  input wire o_rxd_oe_n,
  input wire o_txd,
  input wire o_irq
);
  // ----------------------------------------
  // Helper counter
  // ----------------------------------------
  // Saturates so a long idle spell never wraps back into the legal range
  logic [7:0] since_wr;
  wire buf_wr = i_wr && i_addr == 3'h1;
  always @(posedge i_clk) begin
    if (!i_rst_n || buf_wr)
      since_wr <= 8'h00;
    else if (since_wr != 8'hFF)
      since_wr <= since_wr + 8'h01;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  property p_unmapped; i_rd && i_addr > 3'h4 |=> o_rdata == 8'h00; endproperty
  property p_power_control_reg_pad; i_rd && i_addr == 3'h2 |=> o_rdata[5:0] == 6'h00; endproperty
  property p_tx_start; buf_wr |-> ##[1:4] !o_txd; endproperty
  property p_rxd_idle; o_rxd_oe_n |-> o_rxd; endproperty
  property p_oe_span; !o_rxd_oe_n |-> since_wr <= 8'h18; endproperty
  property p_oe_start; $fell(o_rxd_oe_n) |-> since_wr <= 8'h04; endproperty
  property p_irq_fall; $fell(o_irq) |-> $past(i_wr && i_addr == 3'h0, 2); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_power_control_reg_pad: assert property (p_power_control_reg_pad) else $error("power bits not zero");
  a_tx_start: assert property (p_tx_start) else $error("no frame start");
  a_rxd_idle: assert property (p_rxd_idle) else $error("released data not high");
  a_oe_span: assert property (p_oe_span) else $error("shift drive too long");
  a_oe_start: assert property (p_oe_start) else $error("shift drive unprompted");
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
  c_buf_wr: cover property (buf_wr);
  c_irq: cover property ($rose(o_irq));
  c_shift: cover property ($fell(o_rxd_oe_n));
endmodule // spcs_checker
bind spcs_top spcs_checker spcs_checker_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_rxd(o_rxd), .o_rxd_oe_n(o_rxd_oe_n), .o_txd(o_txd), .o_irq(o_irq));

// ### tb/spcs_peer.sv
// Purpose: Remote serial port facing the transmit and receive lines.
// Assumes: Bit period given in clocks; line idles high.
// Notes: Sends a bad stop bit only when the caller asks for one.
`timescale 1ns/100ps
module spcs_peer (
  input wire i_clk,
  input wire i_line,
  output reg o_line
);
  initial o_line = 1'b1;
  // Start bit, then nb bits LSB first; the last one is the stop bit
  task automatic send(input logic [9:0] frm, input int nb, input int per);
    for (int k = 0; k <= nb; k++) begin
      @(posedge i_clk);
      o_line <= (k == 0) ? 1'b0 : frm[k-1];
      repeat (per - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_line <= 1'b1;
    repeat (per) @(posedge i_clk);
  endtask
  // Samples mid-bit on the falling clock, away from the line's update edge
  task automatic recv(output logic [9:0] frm, input int nb, input int per);
    frm = 10'h000;
    @(negedge i_line);
    repeat (per / 2) @(negedge i_clk);
    for (int k = 0; k < nb; k++) begin
      repeat (per) @(negedge i_clk);
      frm[k] = i_line;
    end
  endtask
endmodule // spcs_peer

// ### tb/test_spcs_top.sv
// Purpose: Self-checking bench of the serial port control block.
// Assumes: Peer on the lines; timer overflow every second clock.
// Notes: Mode 2 runs at 16 clocks a bit, modes 1 and 3 at 32.
`timescale 1ns/100ps
module test_spcs_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic t1_ovf = 1'b0;
  wire rxd, rxd_o, oe_n, txd, irq;
  wire [7:0] rdata;
  int mismatches = 0;
  int cmp_count = 0;
  int m;
  logic [7:0] d, b, ga;
  logic [7:0] q [4];
  logic [9:0] f;
  logic n9;
  always #4 clk = ~clk;
  always @(posedge clk) t1_ovf <= ~t1_ovf;
  spcs_top spcs_top_i (.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_t1_ovf(t1_ovf), .i_rxd(rxd), .o_rxd(rxd_o),
    .o_rxd_oe_n(oe_n), .o_txd(txd), .o_irq(irq));
  spcs_peer spcs_peer_i (.i_clk(clk), .i_line(txd), .o_line(rxd));
  function automatic int per(input int md);
    return (md == 2) ? 16 : 32;
  endfunction
  function automatic int nbits(input int md);
    return (md == 1) ? 9 : 10;
  endfunction
  function automatic logic [7:0] ctl(input int md, input logic fl, rn, tb, rb, ri);
    return {md[1:0], fl, rn, tb, rb, 1'b0, ri};
  endfunction
  task results;
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    results;
  end
  initial begin
    void'($urandom(10));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd_reg(a[2:0], d);
      chk(d, (a == 4) ? 8'hFF : 8'h00);
    end
    wr_reg(3'h2, 8'h80);
    ga = {1'b0, 7'($urandom)};
    wr_reg(3'h3, ga);
    // ----------------------------------------
    // Each frame mode, both directions
    // ----------------------------------------
    for (m = 1; m < 4; m++) begin
      n9 = 1'($urandom);
      b = 8'($urandom);
      wr_reg(3'h0, ctl(m, 0, 1, n9, 0, 0));
      wr_reg(3'h1, b);
      spcs_peer_i.recv(f, nbits(m), per(m));
      chk(f[7:0], b);
      chk({7'h00, f[8]}, {7'h00, (m == 1) | n9});
      chk({7'h00, irq}, 8'h01);
      wr_reg(3'h0, ctl(m, 0, 1, n9, 0, 0));
      b = 8'($urandom);
      spcs_peer_i.send((m == 1) ? {2'b11, b} : {1'b1, n9, b}, nbits(m), per(m));
      rd_reg(3'h1, d);
      chk(d, b);
      rd_reg(3'h0, d);
      chk(d, ctl(m, 0, 1, n9, (m == 1) | n9, 1));
    end
    // ----------------------------------------
    // Framing error behind the shared bit
    // ----------------------------------------
    wr_reg(3'h0, 8'h90);
    spcs_peer_i.send({2'b01, 8'h5A}, 10, 16);
    wr_reg(3'h0, 8'h90);
    spcs_peer_i.send({2'b11, 8'hA5}, 10, 16);
    wr_reg(3'h2, 8'hC0);
    rd_reg(3'h0, d);
    chk(d, 8'h95);
    wr_reg(3'h0, 8'h14);
    rd_reg(3'h0, d);
    chk(d, 8'h14);
    chk({7'h00, irq}, 8'h00);
    wr_reg(3'h2, 8'h80);
    rd_reg(3'h0, d);
    chk(d, 8'h94);
    // Address filter: 9-bit cases, then 8-bit cases
    for (int k = 0; k < 7; k++) begin
      m = (k < 4) ? 2 : 1;
      n9 = (k != 0 && k != 4);
      b = (k == 1 || k == 5) ? ga ^ 8'h01 : ((k == 2) ? 8'hFF : ga);
      wr_reg(3'h0, ctl(m, 1, 1, 0, 0, 0));
      spcs_peer_i.send({1'b1, n9, b}, nbits(m), per(m));
      chk({7'h00, irq}, {7'h00, k == 2 || k == 3 || k == 6});
    end
    wr_reg(3'h0, 8'h80);
    spcs_peer_i.send({2'b11, ga}, 10, 16);
    chk({7'h00, irq}, 8'h00);
    // ----------------------------------------
    // Buffer fill while software stalls
    // ----------------------------------------
    wr_reg(3'h0, 8'h90);
    for (int i = 0; i < 4; i++) begin
      q[i] = 8'($urandom);
      spcs_peer_i.send({2'b11, q[i]}, 10, 16);
    end
    for (int i = 0; i < 3; i++) begin
      rd_reg(3'h1, d);
      chk(d, q[i]);
      wr_reg(3'h0, 8'h90);
      repeat (4) @(posedge clk);
    end
    chk({7'h00, irq}, 8'h00);
    // ----------------------------------------
    // Shift register mode
    // ----------------------------------------
    wr_reg(3'h0, 8'h00);
    b = 8'($urandom);
    wr_reg(3'h1, b);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      #1 d[i] = rxd_o;
    end
    chk(d, b);
    repeat (4) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    wr_reg(3'h0, 8'h10);
    repeat (40) @(posedge clk);
    rd_reg(3'h1, d);
    chk(d, 8'hFF);
    results;
  end
endmodule // test_spcs_top
